// ==== hw/cscr_regs.sv ====
// charger status and control registers at offsets 0x04 to 0x06
`timescale 1ns/10ps

// Summary of operation
// R1 - read-only two-bit field reports the captured regulation loop: none, dpm, ilim, thermal
// R2 - captured loop code holds until the register is read; first loop wins
// R3 - only one regulation loop is granted control at any time
// R4 - reduced current bit forces 330mA instead of the 0x03 setting; resets to 0
// R5 - writing 1 to bit 4 starts one port detection; bit clears when it ends; a write in the ending cycle keeps the bit set but starts nothing
// R6 - bit 3 of 0x04 reads the charge-enable pin level
// R7 - input threshold is 4.20V plus 80mV steps; field resets to 010
// R8 - slowing bit set halves timer speed during thermal, dpm or power path loops
// R9 - limit field: 00 45min, 01 6h reset, 10 9h, 11 timers off
// R10 - disconnect bit with input removed turns the battery FET off
// R11 - thermistor fault code field reports normal, cold, cool, freeze or open
// R12 - thermistor disable bit 1 stops monitoring; only on parts with the pin
// R13 - three-bit overvoltage field decodes 6.0V through 10.5V
// R14 - 0x06 resets to e0 on standalone-only parts, 20 otherwise
// R15 - release bit turns off the 0.6V source on the plus data line
// R16 - forced detection bit runs battery detection always, else on termination or permit
// R17 - test mode bit enters production test only if the fused permit is set
// R18 - test mode is refused while a battery is present
// R19 - standalone after power-up until a host write, and again on watchdog expiry
module cscr_regs
  import cscr_pkg::*;
#(
  parameter bit STANDALONE_ONLY = 1'b0,
  parameter bit HAS_THERMISTOR  = 1'b1
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // register port from the serial engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // pins and analog status, asynchronous
  input  wire logic        ce_pin,
  input  wire logic        input_present,
  input  wire logic        battery_present,
  input  wire logic        fused_test_mode_permit,
  input  wire logic        dpm_loop_req,
  input  wire logic        ilim_loop_req,
  input  wire logic        thermal_loop_req,
  input  wire logic        power_path_management,
  input  wire logic        termination_done,
  input  wire logic [2:0]  thermistor_raw_code,
  // digital core, same clock
  input  wire logic        detect_done,
  input  wire logic        watchdog_expired,
  input  wire logic [4:0]  charge_current_code,
  // regulation and mode outputs
  output logic [1:0]       loop_grant,
  output logic             host_mode,
  output logic [11:0]      charge_current_ma,
  output logic [13:0]      input_voltage_threshold_mv,
  output logic [13:0]      input_overvoltage_mv,
  // timer outputs
  output logic             timer_half_speed,
  output logic [9:0]       safety_limit_min,
  output logic             safety_timer_off,
  // power path and detection outputs
  output logic             battery_fet_off,
  output logic             detect_start,
  output logic             release_plus_line_source,
  output logic             battery_detect_run,
  output logic             thermistor_monitor_en,
  output logic             production_test_mode
);
  localparam logic [7:0] OVP_RST = STANDALONE_ONLY ? CSCR_OVP_RST_ALONE : CSCR_OVP_RST_HOSTCAP;

  // synchronised inputs
  logic [11:0] raw_in;
  logic [11:0] sync_in;
  logic        ce_s;
  logic        present_s;
  logic        batt_s;
  logic        fused_s;
  logic        dpm_s;
  logic        ilim_s;
  logic        therm_s;
  logic        power_path_management_s;
  logic        term_s;
  logic [2:0]  tcode_s;

  assign raw_in = {thermistor_raw_code, termination_done, power_path_management,
                   thermal_loop_req, ilim_loop_req, dpm_loop_req,
                   fused_test_mode_permit, battery_present, input_present, ce_pin};
  assign {tcode_s, term_s, power_path_management_s, therm_s, ilim_s, dpm_s,
          fused_s, batt_s, present_s, ce_s} = sync_in;

  cscr_sync #(
    .W (12)
  ) u_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  // loop arbitration and capture
  logic [1:0] grant_code;
  logic [1:0] held_code;
  logic       loop_clr;

  assign loop_clr = reg_rd && reg_addr == CSCR_ADDR_LOOP;

  cscr_loop_capture u_loop (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .dpm_req     (dpm_s),
    .ilim_req    (ilim_s),
    .thermal_req (therm_s),
    .status_clr  (loop_clr),
    .grant_q     (grant_code),
    .held_q      (held_code)
  );

  // software-written fields
  logic       lowchg_q,  lowchg_d;
  logic       detect_q,  detect_d;
  logic [2:0] dpm_q,     dpm_d;
  logic       slow_q,    slow_d;
  logic [1:0] limit_q,   limit_d;
  logic       battery_disconnect_enable_q,  battery_disconnect_enable_d;
  logic       tdis_q,    tdis_d;
  logic [7:0] ovp_reg_q, ovp_reg_d;
  logic       wr_loop;
  logic       wr_timer;
  logic       wr_ovp;

  assign wr_loop  = reg_wr && reg_addr == CSCR_ADDR_LOOP;
  assign wr_timer = reg_wr && reg_addr == CSCR_ADDR_TIMER;
  assign wr_ovp   = reg_wr && reg_addr == CSCR_ADDR_OVP;

  always_comb begin
    lowchg_d  = lowchg_q;
    detect_d  = detect_q;
    dpm_d     = dpm_q;
    slow_d    = slow_q;
    limit_d   = limit_q;
    battery_disconnect_enable_d  = battery_disconnect_enable_q;
    tdis_d    = tdis_q;
    ovp_reg_d = ovp_reg_q;
    if (detect_done) begin
      detect_d = 1'b0; // [R5]
    end
    if (wr_loop) begin
      lowchg_d = reg_wdata[CSCR_LOWCHG_BIT]; // [R4]
      dpm_d    = reg_wdata[CSCR_DPM_LSB +: 3]; // [R7]
      // a new request in the finishing cycle must survive the clear
      if (reg_wdata[CSCR_DETECT_BIT]) begin
        detect_d = 1'b1; // [R5]
      end
    end
    if (wr_timer) begin
      slow_d   = reg_wdata[CSCR_SLOW_BIT]; // [R8]
      limit_d  = reg_wdata[CSCR_LIMIT_LSB +: 2]; // [R9]
      battery_disconnect_enable_d = reg_wdata[CSCR_BATTERY_DISCONNECT_ENABLE_BIT]; // [R10]
      tdis_d   = reg_wdata[CSCR_TDIS_BIT]; // [R12]
    end
    if (wr_ovp) begin
      ovp_reg_d = reg_wdata; // [R13]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lowchg_q  <= 1'b0; // [R4]
      detect_q  <= 1'b0;
      dpm_q     <= CSCR_DPM_RST; // [R7]
      slow_q    <= CSCR_SLOW_RST;
      limit_q   <= CSCR_LIMIT_RST; // [R9]
      battery_disconnect_enable_q  <= CSCR_BATTERY_DISCONNECT_ENABLE_RST;
      tdis_q    <= CSCR_TDIS_RST;
      ovp_reg_q <= OVP_RST; // [R14]
    end else begin
      lowchg_q  <= lowchg_d;
      detect_q  <= detect_d;
      dpm_q     <= dpm_d;
      slow_q    <= slow_d;
      limit_q   <= limit_d;
      battery_disconnect_enable_q  <= battery_disconnect_enable_d;
      tdis_q    <= tdis_d;
      ovp_reg_q <= ovp_reg_d;
    end
  end

  // host or standalone mode
  cscr_mode_t mode_q, mode_d;

  always_comb begin
    case (mode_q)
      CSCR_MODE_ALONE: begin
        mode_d = (reg_wr && !watchdog_expired) ? CSCR_MODE_HOST : CSCR_MODE_ALONE; // [R19]
      end
      CSCR_MODE_HOST: begin
        mode_d = watchdog_expired ? CSCR_MODE_ALONE : CSCR_MODE_HOST; // [R19]
      end
      default: begin
        mode_d = CSCR_MODE_ALONE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_q <= CSCR_MODE_ALONE; // [R19]
    end else begin
      mode_q <= mode_d;
    end
  end

  // production test mode, latched only from a battery-free start
  logic ptm_q, ptm_d;

  always_comb begin
    ptm_d = ovp_reg_q[CSCR_PTM_BIT] && fused_s && (ptm_q || !batt_s); // [R17] [R18]
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ptm_q <= 1'b0;
    end else begin
      ptm_q <= ptm_d;
    end
  end

  // read data
  logic [2:0] tfault;
  logic [7:0] rdata_d;

  always_comb begin
    // a disabled or absent thermistor reads as open
    tfault  = (tdis_q || !HAS_THERMISTOR) ? CSCR_THERM_OPEN : tcode_s; // [R11] [R12]
    rdata_d = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        CSCR_ADDR_LOOP: begin
          rdata_d = {held_code, lowchg_q, detect_q, ce_s, dpm_q}; // [R1] [R6]
        end
        CSCR_ADDR_TIMER: begin
          rdata_d = {slow_q, limit_q, battery_disconnect_enable_q, tdis_q, tfault}; // [R11]
        end
        CSCR_ADDR_OVP: begin
          rdata_d = ovp_reg_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // registered control outputs
  logic        host_d;
  logic [11:0] chg_d;
  logic [13:0] dpm_mv_d;
  logic [13:0] ovp_mv_d;
  logic        half_d;
  logic [9:0]  limit_min_d;
  logic        toff_d;
  logic        fet_off_d;
  logic        start_d;
  logic        release_d;
  logic        batdet_d;
  logic        tmon_d;

  always_comb begin
    host_d = mode_d == CSCR_MODE_HOST;
    // zero means the external resistor sets the level, as in standalone mode
    if (mode_q == CSCR_MODE_HOST) begin
      chg_d    = lowchg_q ? CSCR_REDUCED_CURRENT_SELECT_MA : cscr_ichg_ma(charge_current_code); // [R4] [R19]
      dpm_mv_d = cscr_dpm_mv(dpm_q); // [R7] [R19]
    end else begin
      chg_d    = 12'h000;
      dpm_mv_d = 14'h0000;
    end
    ovp_mv_d    = cscr_ovp_mv(ovp_reg_q[CSCR_OVP_LSB +: 3]); // [R13]
    half_d      = slow_q && (therm_s || dpm_s || power_path_management_s); // [R8]
    limit_min_d = cscr_limit_min(limit_q); // [R9]
    toff_d      = limit_q == 2'h3; // [R9]
    fet_off_d   = battery_disconnect_enable_q && !present_s; // [R10]
    start_d     = wr_loop && reg_wdata[CSCR_DETECT_BIT] && !detect_q; // [R5]
    release_d   = ovp_reg_q[CSCR_RELEASE_BIT]; // [R15]
    batdet_d    = ovp_reg_q[CSCR_BATDET_BIT] || term_s || fused_s; // [R16]
    tmon_d      = HAS_THERMISTOR && !tdis_q; // [R12]
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      loop_grant                 <= CSCR_LOOP_NONE;
      host_mode                  <= 1'b0;
      charge_current_ma          <= 12'h000;
      input_voltage_threshold_mv <= 14'h0000;
      input_overvoltage_mv       <= 14'h0000;
      timer_half_speed           <= 1'b0;
      safety_limit_min           <= 10'h000;
      safety_timer_off           <= 1'b0;
      battery_fet_off            <= 1'b0;
      detect_start               <= 1'b0;
      release_plus_line_source   <= 1'b0;
      battery_detect_run         <= 1'b0;
      thermistor_monitor_en      <= 1'b0;
      production_test_mode       <= 1'b0;
    end else begin
      loop_grant                 <= grant_code; // [R3]
      host_mode                  <= host_d;
      charge_current_ma          <= chg_d;
      input_voltage_threshold_mv <= dpm_mv_d;
      input_overvoltage_mv       <= ovp_mv_d;
      timer_half_speed           <= half_d;
      safety_limit_min           <= limit_min_d;
      safety_timer_off           <= toff_d;
      battery_fet_off            <= fet_off_d;
      detect_start               <= start_d;
      release_plus_line_source   <= release_d;
      battery_detect_run         <= batdet_d;
      thermistor_monitor_en      <= tmon_d;
      production_test_mode       <= ptm_q; // [R17]
    end
  end
endmodule

// ==== hw/cscr_pkg.sv ====
// constants, types and decoders shared by the charger status and control registers
package cscr_pkg;

  // register offsets
  localparam logic [7:0] CSCR_ADDR_LOOP  = 8'h04;
  localparam logic [7:0] CSCR_ADDR_TIMER = 8'h05;
  localparam logic [7:0] CSCR_ADDR_OVP   = 8'h06;

  // field positions, offset 0x04
  localparam int CSCR_LOOP_LSB     = 6;
  localparam int CSCR_LOWCHG_BIT   = 5;
  localparam int CSCR_DETECT_BIT   = 4;
  localparam int CSCR_CE_BIT       = 3;
  localparam int CSCR_DPM_LSB      = 0;
  // field positions, offset 0x05
  localparam int CSCR_SLOW_BIT     = 7;
  localparam int CSCR_LIMIT_LSB    = 5;
  localparam int CSCR_BATTERY_DISCONNECT_ENABLE_BIT   = 4;
  localparam int CSCR_TDIS_BIT     = 3;
  localparam int CSCR_TCODE_LSB    = 0;
  // field positions, offset 0x06
  localparam int CSCR_OVP_LSB      = 5;
  localparam int CSCR_RELEASE_BIT  = 4;
  localparam int CSCR_BATDET_BIT   = 3;
  localparam int CSCR_PTM_BIT      = 2;
  localparam int CSCR_SPARE_LSB    = 0;

  // reset values
  localparam logic [2:0] CSCR_DPM_RST          = 3'h2;
  localparam logic       CSCR_SLOW_RST         = 1'h1;
  localparam logic [1:0] CSCR_LIMIT_RST        = 2'h1;
  localparam logic       CSCR_BATTERY_DISCONNECT_ENABLE_RST       = 1'h0;
  localparam logic       CSCR_TDIS_RST         = 1'h1;
  localparam logic [7:0] CSCR_OVP_RST_ALONE    = 8'he0;
  localparam logic [7:0] CSCR_OVP_RST_HOSTCAP  = 8'h20;

  // loop status codes
  localparam logic [1:0] CSCR_LOOP_NONE    = 2'h0;
  localparam logic [1:0] CSCR_LOOP_DPM     = 2'h1;
  localparam logic [1:0] CSCR_LOOP_ILIM    = 2'h2;
  localparam logic [1:0] CSCR_LOOP_THERMAL = 2'h3;

  // thermistor fault codes
  localparam logic [2:0] CSCR_THERM_NORMAL = 3'h0;
  localparam logic [2:0] CSCR_THERM_COLD   = 3'h4;
  localparam logic [2:0] CSCR_THERM_COOL   = 3'h5;
  localparam logic [2:0] CSCR_THERM_FREEZE = 3'h6;
  localparam logic [2:0] CSCR_THERM_OPEN   = 3'h7;

  // analog settings
  localparam logic [13:0] CSCR_DPM_OFFSET_MV = 14'd4200;
  localparam logic [13:0] CSCR_DPM_STEP_MV   = 14'd80;
  localparam logic [11:0] CSCR_REDUCED_CURRENT_SELECT_MA    = 12'd330;
  localparam logic [11:0] CSCR_ICHG_BASE_MA  = 12'd500;
  localparam logic [11:0] CSCR_ICHG_STEP_MA  = 12'd50;

  typedef enum logic [1:0] {
    CSCR_MODE_ALONE = 2'b01,
    CSCR_MODE_HOST  = 2'b10
  } cscr_mode_t;

  function automatic logic [13:0] cscr_dpm_mv(input logic [2:0] code);
    return 14'(CSCR_DPM_OFFSET_MV + 14'(code) * CSCR_DPM_STEP_MV);
  endfunction

  function automatic logic [11:0] cscr_ichg_ma(input logic [4:0] code);
    return 12'(CSCR_ICHG_BASE_MA + 12'(code) * CSCR_ICHG_STEP_MA);
  endfunction

  function automatic logic [13:0] cscr_ovp_mv(input logic [2:0] code);
    case (code)
      3'h0:    return 14'd6000;
      3'h1:    return 14'd6500;
      3'h2:    return 14'd7000;
      3'h3:    return 14'd8000;
      3'h4:    return 14'd9000;
      3'h5:    return 14'd9500;
      3'h6:    return 14'd10000;
      default: return 14'd10500;
    endcase
  endfunction

  // minutes; zero when the timers are off
  function automatic logic [9:0] cscr_limit_min(input logic [1:0] code);
    case (code)
      2'h0:    return 10'd45;
      2'h1:    return 10'd360;
      2'h2:    return 10'd540;
      default: return 10'd0;
    endcase
  endfunction

endpackage

// ==== hw/cscr_sync.sv ====
// two-stage synchroniser for a group of level inputs
`timescale 1ns/10ps
module cscr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule

// ==== hw/cscr_loop_capture.sv ====
// picks the one regulation loop in control and latches the first one seen
`timescale 1ns/10ps
module cscr_loop_capture
  import cscr_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // loop requests, already synchronised
  input  wire logic       dpm_req,
  input  wire logic       ilim_req,
  input  wire logic       thermal_req,
  // clear from a status read
  input  wire logic       status_clr,
  // results
  output logic      [1:0] grant_q,
  output logic      [1:0] held_q
);
  logic [1:0] grant_d;
  logic [1:0] held_d;
  logic       keep;

  always_comb begin
    // a loop keeps control while it still asks, so control never flips between two
    case (grant_q)
      CSCR_LOOP_DPM:     keep = dpm_req;
      CSCR_LOOP_ILIM:    keep = ilim_req;
      CSCR_LOOP_THERMAL: keep = thermal_req;
      default:           keep = 1'b0;
    endcase
    if (keep) begin
      grant_d = grant_q; // [R3]
    end else if (thermal_req) begin
      grant_d = CSCR_LOOP_THERMAL; // [R3]
    end else if (ilim_req) begin
      grant_d = CSCR_LOOP_ILIM;
    end else if (dpm_req) begin
      grant_d = CSCR_LOOP_DPM;
    end else begin
      grant_d = CSCR_LOOP_NONE;
    end
    // a loop active in the read cycle is caught again, so the read loses nothing
    if (status_clr || held_q == CSCR_LOOP_NONE) begin
      held_d = grant_q; // [R2]
    end else begin
      held_d = held_q; // [R2]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      grant_q <= CSCR_LOOP_NONE;
      held_q  <= CSCR_LOOP_NONE;
    end else begin
      grant_q <= grant_d;
      held_q  <= held_d;
    end
  end
endmodule

// ==== bench/cscr_regs_sva.sv ====
// port-level assertions for the charger status and control registers
`timescale 1ns/10ps
module cscr_regs_sva
  import cscr_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  // pins and status
  input wire logic        ce_pin,
  input wire logic        input_present,
  input wire logic        battery_present,
  input wire logic        fused_test_mode_permit,
  input wire logic        dpm_loop_req,
  input wire logic        ilim_loop_req,
  input wire logic        thermal_loop_req,
  input wire logic        watchdog_expired,
  // outputs
  input wire logic [1:0]  loop_grant,
  input wire logic        host_mode,
  input wire logic [11:0] charge_current_ma,
  input wire logic        battery_fet_off,
  input wire logic        detect_start,
  input wire logic        production_test_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // six quiet samples cover the two-flop synchroniser plus two register stages
  a_grant_none: assert property (
    (!dpm_loop_req && !ilim_loop_req && !thermal_loop_req)[*6] |-> loop_grant == CSCR_LOOP_NONE)
    else $error("loop grant not cleared");
  a_grant_thermal: assert property (
    (thermal_loop_req && !ilim_loop_req && !dpm_loop_req)[*6] |-> loop_grant == CSCR_LOOP_THERMAL)
    else $error("thermal loop not granted");
  a_current_low: assert property (
    reg_wr && reg_addr == CSCR_ADDR_LOOP && reg_wdata[CSCR_LOWCHG_BIT] && !watchdog_expired
    ##1 (!reg_wr && !watchdog_expired)[*3] |-> charge_current_ma == CSCR_REDUCED_CURRENT_SELECT_MA)
    else $error("reduced current not applied");
  a_detect_pulse: assert property (
    reg_wr && reg_addr == CSCR_ADDR_LOOP && reg_wdata[CSCR_DETECT_BIT]
    |=> detect_start ##1 !detect_start)
    else $error("detection start is not one pulse");
  a_ce_read: assert property (
    (ce_pin && !reg_rd)[*4] ##1 (ce_pin && reg_rd && reg_addr == CSCR_ADDR_LOOP)
    |=> reg_rdata[CSCR_CE_BIT])
    else $error("charge enable level not read back");
  a_fet_on: assert property (
    input_present[*6] |-> !battery_fet_off)
    else $error("battery switched off with input present");
  a_mode_write: assert property (
    reg_wr && !watchdog_expired |=> host_mode)
    else $error("write did not enter host mode");
  a_mode_expire: assert property (
    watchdog_expired |=> !host_mode)
    else $error("expiry did not leave host mode");
  a_test_refused: assert property (
    battery_present[*6] |-> !$rose(production_test_mode))
    else $error("test mode entered with battery present");
  a_test_permit: assert property (
    (!fused_test_mode_permit)[*6] |-> !production_test_mode)
    else $error("test mode without fused permit");
endmodule

bind cscr_regs cscr_regs_sva u_sva (
  .clk_sys, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .ce_pin,
  .input_present, .battery_present, .fused_test_mode_permit, .dpm_loop_req, .ilim_loop_req,
  .thermal_loop_req, .watchdog_expired, .loop_grant, .host_mode, .charge_current_ma,
  .battery_fet_off, .detect_start, .production_test_mode
);

// ==== bench/cscr_regs_bench.sv ====
// self-checking bench for the charger status and control registers
`timescale 1ns/10ps
module cscr_regs_bench;
  import cscr_pkg::*;
  logic        clk_sys, nrst, reg_wr, reg_rd, ce_pin, input_present, battery_present;
  logic        fused_test_mode_permit, dpm_loop_req, ilim_loop_req, thermal_loop_req;
  logic        power_path_management, termination_done, detect_done, watchdog_expired;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_q;
  logic [7:0]  alone_rdata;
  logic [13:0] alone_ovp_mv;
  logic [2:0]  thermistor_raw_code;
  logic [4:0]  charge_current_code;
  logic [1:0]  loop_grant;
  logic        host_mode, timer_half_speed, safety_timer_off, battery_fet_off, detect_start;
  logic        release_plus_line_source, battery_detect_run, thermistor_monitor_en;
  logic        production_test_mode;
  logic [11:0] charge_current_ma;
  logic [13:0] input_voltage_threshold_mv, input_overvoltage_mv;
  logic [9:0]  safety_limit_min;
  logic [9:0]  lims [4] = '{10'd45, 10'd360, 10'd540, 10'd0};
  logic [2:0]  codes [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [13:0] ovp [8] = '{14'd6000, 14'd6500, 14'd7000, 14'd8000,
                           14'd9000, 14'd9500, 14'd10000, 14'd10500};
  int          failures = 0;
  int          checked = 0;
  int          starts = 0;

  cscr_regs DUT (
    .clk_sys, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .ce_pin,
    .input_present, .battery_present, .fused_test_mode_permit, .dpm_loop_req, .ilim_loop_req,
    .thermal_loop_req, .power_path_management, .termination_done, .thermistor_raw_code,
    .detect_done, .watchdog_expired, .charge_current_code, .loop_grant, .host_mode,
    .charge_current_ma, .input_voltage_threshold_mv, .input_overvoltage_mv, .timer_half_speed,
    .safety_limit_min, .safety_timer_off, .battery_fet_off, .detect_start,
    .release_plus_line_source, .battery_detect_run, .thermistor_monitor_en, .production_test_mode
  );

  // the standalone-only variant differs only in its 0x06 reset value
  cscr_regs #(
    .STANDALONE_ONLY (1'b1)
  ) DUT_ALONE (
    .clk_sys, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata (alone_rdata),
    .ce_pin, .input_present, .battery_present, .fused_test_mode_permit, .dpm_loop_req,
    .ilim_loop_req, .thermal_loop_req, .power_path_management, .termination_done,
    .thermistor_raw_code, .detect_done, .watchdog_expired, .charge_current_code,
    .loop_grant (), .host_mode (), .charge_current_ma (), .input_voltage_threshold_mv (),
    .input_overvoltage_mv (alone_ovp_mv), .timer_half_speed (), .safety_limit_min (),
    .safety_timer_off (), .battery_fet_off (), .detect_start (), .release_plus_line_source (),
    .battery_detect_run (), .thermistor_monitor_en (), .production_test_mode ()
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (detect_start === 1'b1)
      starts++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // the extra idle cycle keeps back-to-back calls from toggling a strobe twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    rd_q = reg_rdata;
  endtask

  task automatic t_reset;
    rd(CSCR_ADDR_LOOP);
    chk(rd_q, 8'h02);
    rd(CSCR_ADDR_TIMER);
    chk(rd_q, 8'haf);
    rd(CSCR_ADDR_OVP);
    chk(rd_q, 8'h20);
    chk({alone_rdata, alone_ovp_mv}, {8'he0, 14'd10500});
    chk({host_mode, charge_current_ma}, 13'h0);
    chk({input_overvoltage_mv, safety_limit_min}, {14'd6500, 10'd360});
    chk(thermistor_monitor_en, 1'b0);
  endtask

  task automatic t_host;
    ce_pin = 1'b1;
    charge_current_code = 5'h03;
    wr(CSCR_ADDR_LOOP, 8'he7);
    step(4);
    chk({host_mode, charge_current_ma}, {1'b1, 12'd330});
    chk(input_voltage_threshold_mv, 14'd4760);
    rd(CSCR_ADDR_LOOP);
    chk(rd_q, 8'h2f);
    wr(CSCR_ADDR_LOOP, 8'h07);
    step(4);
    chk(charge_current_ma, 12'd650);
    watchdog_expired = 1'b1;
    step(1);
    watchdog_expired = 1'b0;
    step(4);
    chk({host_mode, charge_current_ma}, 13'h0);
    wr(8'h07, 8'hff);
    rd(8'h07);
    chk({host_mode, rd_q}, 9'h100);
  endtask

  task automatic t_detect;
    wr(CSCR_ADDR_LOOP, 8'h10);
    rd(CSCR_ADDR_LOOP);
    chk(rd_q, 8'h18);
    detect_done = 1'b1;
    step(1);
    detect_done = 1'b0;
    step(2);
    rd(CSCR_ADDR_LOOP);
    chk({starts[7:0], rd_q}, 16'h0108);
  endtask

  task automatic t_timer;
    for (int c = 0; c < 4; c++) begin
      wr(CSCR_ADDR_TIMER, {1'b1, 2'(c), 5'h10});
      step(3);
      chk({safety_timer_off, safety_limit_min}, {c == 3, lims[c]});
    end
    chk({battery_fet_off, thermistor_monitor_en}, 2'b11);
    input_present = 1'b1;
    step(4);
    chk(battery_fet_off, 1'b0);
    for (int i = 0; i < 5; i++) begin
      thermistor_raw_code = codes[i];
      step(4);
      rd(CSCR_ADDR_TIMER);
      chk(rd_q[2:0], codes[i]);
    end
    power_path_management = 1'b1;
    wr(CSCR_ADDR_TIMER, 8'hb0);
    step(4);
    chk(timer_half_speed, 1'b1);
    wr(CSCR_ADDR_TIMER, 8'h30);
    step(3);
    chk(timer_half_speed, 1'b0);
    power_path_management = 1'b0;
  endtask

  // the first owner keeps control; the held code survives a takeover until read
  task automatic t_loop;
    dpm_loop_req = 1'b1;
    step(6);
    chk(loop_grant, CSCR_LOOP_DPM);
    thermal_loop_req = 1'b1;
    step(6);
    chk(loop_grant, CSCR_LOOP_DPM);
    dpm_loop_req = 1'b0;
    step(6);
    chk(loop_grant, CSCR_LOOP_THERMAL);
    rd(CSCR_ADDR_LOOP);
    chk(rd_q[7:6], CSCR_LOOP_DPM);
    rd(CSCR_ADDR_LOOP);
    chk(rd_q[7:6], CSCR_LOOP_THERMAL);
    thermal_loop_req = 1'b0;
    ilim_loop_req = 1'b1;
    step(6);
    chk(loop_grant, CSCR_LOOP_ILIM);
    ilim_loop_req = 1'b0;
    step(6);
    rd(CSCR_ADDR_LOOP);
    chk(rd_q[7:6], CSCR_LOOP_THERMAL);
    rd(CSCR_ADDR_LOOP);
    chk({loop_grant, rd_q[7:6]}, 4'h0);
  endtask

  task automatic t_ovp;
    for (int c = 0; c < 8; c++) begin
      wr(CSCR_ADDR_OVP, {3'(c), 5'h00});
      step(2);
      chk(input_overvoltage_mv, ovp[c]);
    end
    wr(CSCR_ADDR_OVP, 8'h18);
    rd(CSCR_ADDR_OVP);
    chk({release_plus_line_source, battery_detect_run, rd_q}, 10'h318);
    wr(CSCR_ADDR_OVP, 8'h00);
    step(3);
    chk({release_plus_line_source, battery_detect_run}, 2'b00);
    termination_done = 1'b1;
    step(4);
    chk(battery_detect_run, 1'b1);
    termination_done = 1'b0;
  endtask

  task automatic t_test;
    battery_present = 1'b1;
    fused_test_mode_permit = 1'b1;
    step(4);
    wr(CSCR_ADDR_OVP, 8'h04);
    step(4);
    chk(production_test_mode, 1'b0);
    battery_present = 1'b0;
    wr(CSCR_ADDR_OVP, 8'h00);
    step(4);
    wr(CSCR_ADDR_OVP, 8'h04);
    step(3);
    chk(production_test_mode, 1'b1);
    battery_present = 1'b1;
    step(4);
    chk(production_test_mode, 1'b1);
    fused_test_mode_permit = 1'b0;
    step(4);
    chk(production_test_mode, 1'b0);
  endtask

  initial begin
    nrst = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, ce_pin, input_present, battery_present} = '0;
    {fused_test_mode_permit, dpm_loop_req, ilim_loop_req, thermal_loop_req} = '0;
    {power_path_management, termination_done, detect_done, watchdog_expired} = '0;
    charge_current_code = 5'h00;
    thermistor_raw_code = 3'h4;
    repeat (10) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    step(2);
    t_reset();
    t_host();
    t_detect();
    t_timer();
    t_loop();
    t_ovp();
    t_test();
    print_verdict();
  end

  // the sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
endmodule
